// ### icc_cfg.svh
`ifndef ICC_CFG_SVH
`define ICC_CFG_SVH
// register byte offsets
`define ICC_OFS_CTRL 12'h000
`define ICC_OFS_BUF 12'h004
`define ICC_OFS_IRQ_STAT 12'h008
`define ICC_OFS_IRQ_MASK 12'h00c
// control field positions
`define ICC_BIT_ENABLE 15
`define ICC_BIT_IDLE_HALT 13
`define ICC_BIT_FIRST_EDGE 9
`define ICC_BIT_WIDE 8
`define ICC_BIT_SRC 7
`define ICC_BIT_IRQ_HI 6
`define ICC_BIT_IRQ_LO 5
`define ICC_BIT_OVF 4
`define ICC_BIT_BNE 3
`define ICC_BIT_MODE_HI 2
`define ICC_BIT_MODE_LO 0
// writable control bits mask and reset value
`define ICC_CTRL_WMASK 32'h0000a3e7
`define ICC_CTRL_RESET 32'h00000000
// capture modes
`define ICC_MODE_OFF 3'h0
`define ICC_MODE_ANY 3'h1
`define ICC_MODE_FALL 3'h2
`define ICC_MODE_RISE 3'h3
`define ICC_MODE_RISE4 3'h4
`define ICC_MODE_RISE16 3'h5
`define ICC_MODE_FIRST 3'h6
// interrupt interval codes
`define ICC_IRQ_EVERY2 2'h0
`define ICC_IRQ_EVERY1 2'h1
`define ICC_IRQ_EVERY3 2'h2
`define ICC_IRQ_EVERY4 2'h3
// status bits
`define ICC_STAT_CAPTURE 0
`define ICC_STAT_OVERFLOW 1
// buffer depth
`define ICC_BUF_DEPTH 4
`define ICC_BUF_AW 2
`endif

// ### icc_pkg.sv
package icc_pkg;
  typedef struct packed {
    logic enable;
    logic idle_halt_select;
    logic first_edge_select;
    logic wide_capture_select;
    logic counter_source_select;
    logic [1:0] irq_interval_field;
    logic [2:0] capture_mode_field;
  } icc_ctrl_s;
  typedef struct packed {
    logic [15:0] timer_two_source;
    logic [15:0] timer_three_source;
  } icc_timers_s;
endpackage : icc_pkg

// ### icc_sync.sv
`timescale 1ns/1ps
module icc_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin in, filtered level and edges out
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q, s2_q, s3_q, lvl_q;
  wire agree = (s2_q == s3_q);
  // three stages; level moves only once the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) lvl_q <= s3_q;
    end
  end
  assign level = lvl_q;
  assign rise = agree && s3_q && !lvl_q;
  assign fall = agree && !s3_q && lvl_q;
endmodule : icc_sync

// ### icc_buf.sv
`timescale 1ns/1ps
`include "icc_cfg.svh"
module icc_buf (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  // write side
  input wire logic push,
  input wire logic [31:0] wdata,
  output logic full,
  // read side
  input wire logic pop,
  output logic [31:0] rdata,
  output logic not_empty
);
  logic [31:0] mem_q [`ICC_BUF_DEPTH];
  logic [`ICC_BUF_AW-1:0] wp_q, rp_q;
  logic [`ICC_BUF_AW:0] cnt_q;
  wire do_push = push && !full;
  wire do_pop = pop && not_empty;
  assign full = (cnt_q == (`ICC_BUF_AW+1)'(`ICC_BUF_DEPTH));
  assign not_empty = (cnt_q != '0);
  assign rdata = mem_q[rp_q];
  // pointers and count; a clear drops every entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wp_q <= wp_q + 1'b1;
      if (do_pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + {2'h0, do_push} - {2'h0, do_pop};
    end
  end
  // storage has no reset, only pointed entries are read
  always_ff @(posedge pclk) begin
    if (do_push) mem_q[wp_q] <= wdata;
  end
endmodule : icc_buf

// ### icc_top.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "icc_cfg.svh"
// Behaviour
// - enable low resets channel, stops new interrupt events
// - idle-halt set stops capture in idle
// - mode 110 first edge picks rise/fall
// - wide select captures 32-bit combined value
// - 16-bit source: zero timer_three_source, one timer_two_source
// - interval field sets events per interrupt
// - read-only overflow flag after overflow
// - read-only buffer not empty flag
module icc_top
  import icc_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture pin and timers
  input wire logic cap_pin,
  input wire icc_timers_s timers,
  input wire logic cpu_idle,
  // interrupt
  output logic irq
);
  logic [31:0] ctrl_q;
  logic ovf_q;
  logic [1:0] stat_q, mask_q;
  logic [1:0] ev_cnt_q;
  logic [3:0] pre_cnt_q;
  logic armed_q;
  logic [31:0] prdata_q;
  logic pin_rise, pin_fall;
  logic buf_full, buf_ne;
  logic [31:0] buf_rdata;
  icc_ctrl_s cfg;

  // field view of the control word
  assign cfg.enable = ctrl_q[`ICC_BIT_ENABLE];
  assign cfg.idle_halt_select = ctrl_q[`ICC_BIT_IDLE_HALT];
  assign cfg.first_edge_select = ctrl_q[`ICC_BIT_FIRST_EDGE];
  assign cfg.wide_capture_select = ctrl_q[`ICC_BIT_WIDE];
  assign cfg.counter_source_select = ctrl_q[`ICC_BIT_SRC];
  assign cfg.irq_interval_field = ctrl_q[`ICC_BIT_IRQ_HI:`ICC_BIT_IRQ_LO];
  assign cfg.capture_mode_field = ctrl_q[`ICC_BIT_MODE_HI:`ICC_BIT_MODE_LO];

  // apb decode; zero wait states
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire sel_ctrl = (paddr == `ICC_OFS_CTRL);
  wire sel_buf = (paddr == `ICC_OFS_BUF);
  wire sel_stat = (paddr == `ICC_OFS_IRQ_STAT);
  wire sel_mask = (paddr == `ICC_OFS_IRQ_MASK);
  wire mapped = sel_ctrl || sel_buf || sel_stat || sel_mask;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // channel runs only while enabled and not halted by idle
  wire chan_rst = !cfg.enable;
  wire run = cfg.enable && !(cfg.idle_halt_select && cpu_idle);

  // input conditioning on the pin
  icc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(cap_pin),
    .level(), // only the edges matter here
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // edge qualification per mode; the first-edge bit only matters in mode 110
  wire first_hit = cfg.first_edge_select ? pin_rise : pin_fall;
  wire any_edge = pin_rise || pin_fall;
  logic edge_ok;
  always_comb begin
    edge_ok = 1'b0;
    case (cfg.capture_mode_field)
      `ICC_MODE_OFF: edge_ok = 1'b0;
      `ICC_MODE_ANY: edge_ok = any_edge;
      `ICC_MODE_FALL: edge_ok = pin_fall;
      `ICC_MODE_RISE: edge_ok = pin_rise;
      `ICC_MODE_RISE4: edge_ok = pin_rise && (pre_cnt_q[1:0] == 2'h3);
      `ICC_MODE_RISE16: edge_ok = pin_rise && (pre_cnt_q == 4'hf);
      `ICC_MODE_FIRST: edge_ok = armed_q ? any_edge : first_hit;
      default: edge_ok = 1'b0;
    endcase
  end
  wire cap_ev = run && edge_ok;

  // timer value chosen by width and source select
  wire [15:0] t16 = cfg.counter_source_select ? timers.timer_two_source : timers.timer_three_source;
  wire [31:0] cap_val = cfg.wide_capture_select ? {timers.timer_three_source, timers.timer_two_source}
                                                : {16'h0000, t16};

  // capture buffer; reading the buffer word pops one entry
  wire pop = rd && sel_buf;
  icc_buf u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .clr(chan_rst),
    .push(cap_ev),
    .wdata(cap_val),
    .full(buf_full),
    .pop(pop),
    .rdata(buf_rdata),
    .not_empty(buf_ne)
  );
  wire ovf_ev = cap_ev && buf_full;

  // events per interrupt request
  logic [1:0] ev_limit;
  always_comb begin
    ev_limit = 2'h1;
    case (cfg.irq_interval_field)
      `ICC_IRQ_EVERY1: ev_limit = 2'h0;
      `ICC_IRQ_EVERY2: ev_limit = 2'h1;
      `ICC_IRQ_EVERY3: ev_limit = 2'h2;
      `ICC_IRQ_EVERY4: ev_limit = 2'h3;
      default: ev_limit = 2'h1;
    endcase
  end
  wire ev_done = cap_ev && (ev_cnt_q == ev_limit);
  wire [1:0] ev_set = {ovf_ev, ev_done} & {2{run}};

  // control register; status bits are not writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= `ICC_CTRL_RESET;
    else if (wr && sel_ctrl) ctrl_q <= pwdata & `ICC_CTRL_WMASK;
  end

  // prescale, first-edge arming and event counting, all held in reset while off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= 4'h0;
      armed_q <= 1'b0;
      ev_cnt_q <= 2'h0;
    end else if (chan_rst) begin
      pre_cnt_q <= 4'h0;
      armed_q <= 1'b0;
      ev_cnt_q <= 2'h0;
    end else if (run) begin
      if (pin_rise) pre_cnt_q <= pre_cnt_q + 4'h1;
      if (cap_ev) armed_q <= 1'b1;
      if (cap_ev) ev_cnt_q <= ev_done ? 2'h0 : ev_cnt_q + 2'h1;
    end
  end

  // overflow flag stays until the channel is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ovf_q <= 1'b0;
    else if (chan_rst) ovf_q <= 1'b0;
    else if (ovf_ev) ovf_q <= 1'b1;
  end

  // sticky status; a read clears only the bits it reported, since read data is taken in setup
  // and an event landing between setup and access would otherwise be lost; a new event wins
  wire stat_rd = rd && sel_stat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 2'h0;
      mask_q <= 2'h0;
    end else begin
      stat_q <= (stat_rd ? (stat_q & ~prdata_q[1:0]) : stat_q) | ev_set;
      if (wr && sel_mask) mask_q <= pwdata[1:0];
    end
  end
  assign irq = |(stat_q & mask_q);

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux = ctrl_q;
      rd_mux[`ICC_BIT_OVF] = ovf_q;
      rd_mux[`ICC_BIT_BNE] = buf_ne;
    end else if (sel_buf) begin
      rd_mux = buf_rdata;
    end else if (sel_stat) begin
      rd_mux = {30'h0, stat_q};
    end else if (sel_mask) begin
      rd_mux = {30'h0, mask_q};
    end
  end

  // registered read data, updated in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata_q <= rd_mux;
  end
  assign prdata = prdata_q;
endmodule : icc_top

// ### icc_sva.sv
`timescale 1ns/1ps
`include "icc_cfg.svh"
module icc_sva
  import icc_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin side
  input wire logic cap_pin,
  input wire icc_timers_s timers,
  input wire logic cpu_idle,
  input wire logic irq
);
  logic [31:0] ctl_q;
  logic [31:0] msk_q;
  wire acc = psel && penable;
  wire rd0 = acc && !pwrite && paddr == 12'h000;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadows of software writes, so readback and masking can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 32'h0;
      msk_q <= 32'h0;
    end else if (acc && pwrite && paddr == 12'h000) begin
      ctl_q <= pwdata;
    end else if (acc && pwrite && paddr == 12'h00c) begin
      msk_q <= pwdata;
    end
  end
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_hi; acc && paddr > 12'h00c |-> pslverr; endproperty
  a_err_hi: assert property (p_err_hi) else $error("no error on unmapped");
  property p_err_lo; acc && paddr[1:0] == 2'h0 && paddr <= 12'h00c |-> !pslverr; endproperty
  a_err_lo: assert property (p_err_lo) else $error("error on mapped");
  property p_ctl_rb; rd0 |-> (prdata & `ICC_CTRL_WMASK) == (ctl_q & `ICC_CTRL_WMASK); endproperty
  a_ctl_rb: assert property (p_ctl_rb) else $error("control readback");
  property p_dis_flags; rd0 && !ctl_q[15] && !$past(ctl_q[15]) |-> prdata[4:3] == 2'h0; endproperty
  a_dis_flags: assert property (p_dis_flags) else $error("flags while off");
  property p_irq_mask; msk_q == 32'h0 |-> !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_dis_irq; !ctl_q[15] && !$past(psel) |-> !$rose(irq); endproperty
  a_dis_irq: assert property (p_dis_irq) else $error("irq rose while off");
  property p_idle; (cpu_idle && ctl_q[13] && !psel)[*8] |-> !$rose(irq); endproperty
  a_idle: assert property (p_idle) else $error("irq rose in halted idle");
endmodule : icc_sva
bind icc_top icc_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cap_pin(cap_pin), .timers(timers), .cpu_idle(cpu_idle), .irq(irq));

// ### icc_far.sv
`timescale 1ns/1ps
module icc_far
  import icc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and counters
  output logic cap_pin,
  output icc_timers_s timers
);
  logic [15:0] cnt_q;
  // timer three runs 0x8000 ahead so the chosen source shows in bit 15
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0;
    end else begin
      cnt_q <= cnt_q + 16'h1;
    end
  end
  assign timers = {cnt_q, cnt_q + 16'h8000};
  initial cap_pin = 1'b0;
  // level held six cycles, longer than the input filter
  task automatic drive(input logic lvl);
    @(posedge pclk);
    cap_pin <= lvl;
    repeat (6) @(posedge pclk);
  endtask : drive
endmodule : icc_far

// ### test_input_capture_control.sv
`timescale 1ns/1ps
module test_input_capture_control;
  import icc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, cpu_idle, pready, pslverr, irq, cap_pin, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  icc_timers_s timers;
  int miscompares, num_checks, cyc;
  icc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cap_pin(cap_pin), .timers(timers), .cpu_idle(cpu_idle), .irq(irq));
  icc_far u_far (.pclk(pclk), .presetn(presetn), .cap_pin(cap_pin), .timers(timers));
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic off;
    apb(1'b1, 12'h000, 32'h0);
    @(posedge pclk);
  endtask : off
  task automatic pulse;
    u_far.drive(1'b1);
    u_far.drive(1'b0);
  endtask : pulse
  task automatic t_regs;
    rd(12'h000);
    chk("ctrl reset", 32'h0, rv);
    apb(1'b1, 12'h000, 32'hffff7fff);
    rd(12'h000);
    chk("ctrl rw", 32'h000023e7, rv);
    rd(12'h010);
    chk("unmapped", 32'h1, {31'h0, ev});
    off;
  endtask : t_regs
  // rise mode: timer three, timer two, then wide
  task automatic t_capture;
    logic [31:0] m [3] = '{32'hffff8000, 32'hffff8000, 32'h80008000};
    logic [31:0] e [3] = '{32'h00008000, 32'h0, 32'h80000000};
    logic [15:0] t0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h000, 32'h8003 | (i << 7));
      t0 = u_far.cnt_q;
      u_far.drive(1'b1);
      rd(12'h000);
      chk("bne set", 32'h8, rv & 32'h8);
      rd(12'h004);
      chk("source", e[i], rv & m[i]);
      chk("stamp", 32'h1, {31'h0, (rv[14:0] - t0[14:0]) < 15'hc});
      rd(12'h000);
      chk("bne clear", 32'h0, rv & 32'h8);
      u_far.drive(1'b0);
      off;
    end
  endtask : t_capture
  // interval codes 11, 10 and 00 give every fourth, third and second capture
  task automatic t_interval;
    int n [3] = '{4, 3, 2};
    logic [1:0] code [3] = '{2'h3, 2'h2, 2'h0};
    apb(1'b1, 12'h00c, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h000, 32'h8003 | {25'h0, code[i], 5'h0});
      for (int k = 1; k <= n[i]; k++) begin
        pulse;
        chk("irq", {31'h0, k == n[i]}, {31'h0, irq});
      end
      rd(12'h008);
      @(negedge pclk);
      chk("irq clear", 32'h0, {31'h0, irq});
      off;
    end
  endtask : t_interval
  task automatic t_overflow;
    apb(1'b1, 12'h00c, 32'h2);
    apb(1'b1, 12'h000, 32'h8003);
    repeat (5) pulse;
    rd(12'h000);
    chk("ovf flags", 32'h18, rv & 32'h18);
    chk("ovf irq", 32'h1, {31'h0, irq});
    rd(12'h004);
    chk("oldest", 32'h8000, rv & 32'hffff8000);
    rd(12'h008);
    apb(1'b1, 12'h00c, 32'h0);
    off;
    rd(12'h000);
    chk("flags off", 32'h0, rv & 32'h18);
  endtask : t_overflow
  // with the first-edge bit set the first capture (the rise) is drained so the check after the second edge sees only that edge
  task automatic t_first;
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, 12'h000, 32'h8006 | (f << 9));
      u_far.drive(1'b1);
      rd(12'h000);
      chk("first rise", {28'h0, f[0], 3'h0}, rv & 32'h8);
      if (f == 1) rd(12'h004);
      u_far.drive(1'b0);
      rd(12'h000);
      chk("then fall", 32'h8, rv & 32'h8);
      off;
    end
  endtask : t_first
  task automatic t_idle;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, 12'h000, 32'h8003 | ((1 - s) << 13));
      cpu_idle <= 1'b1;
      pulse;
      cpu_idle <= 1'b0;
      rd(12'h000);
      chk("idle capture", {28'h0, s[0], 3'h0}, rv & 32'h8);
      off;
    end
  endtask : t_idle
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // hang guard, far beyond the few hundred cycles the scenarios need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    // address and write data stay open until the first setup cycle qualifies them
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    cpu_idle = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_capture;
    t_interval;
    t_overflow;
    t_first;
    t_idle;
    conclude;
  end
endmodule : test_input_capture_control
